// ---- ccr_pkg.sv ----
// package: register map, field positions, reset values and timing counts
// of the clock and range configuration register bank.
// assumes: used by every file of this block.
package ccr_pkg;

	localparam logic [14:0] OFS_CLK_COND   = 15'h002B;
	localparam logic [14:0] OFS_SYSREF_EDGE_POSITION_STATUS = 15'h002C;
	localparam logic [14:0] OFS_RANGE_A    = 15'h0030;
	localparam logic [14:0] OFS_RANGE_B    = 15'h0032;
	localparam logic [14:0] OFS_SYSREF_DLY = 15'h0029;

	localparam int          POS_FB_GAIN     = 4;
	localparam int          POS_NOISE_SUPPR = 2;
	localparam int          POS_DELAY_LSB   = 0;
	localparam logic [7:0]  CLK_COND_MASK   = 8'h17;
	localparam logic [7:0]  RST_CLK_COND    = 8'h11;
	localparam logic [23:0] RST_SYSREF_EDGE_POSITION_STATUS  = 24'h000000;
	localparam logic [15:0] RST_RANGE       = 16'hA000;
	localparam logic [15:0] RANGE_MIN_REC   = 16'h2000;
	localparam logic [15:0] RANGE_MAX       = 16'hFFFF;
	localparam logic [1:0]  DELAY_ONEHOT_RST = 2'h1;
	localparam logic [7:0]  SYSREF_DLY_MASK = 8'h0F;
	localparam logic [7:0]  RST_SYSREF_DLY  = 8'h00;

	localparam int          SPI_CMD_BITS  = 24;
	localparam int          SYNC_STAGES   = 2;

	typedef enum logic [1:0] {
		CCR_IDLE,
		CCR_HDR,
		CCR_DATA
	} ccr_phase_e;

endpackage

// ---- ccr_sync.sv ----
// file: two-flop synchroniser for one pin level.
// assumes: one clock; the input comes from a device pin.
`timescale 1ns/1ps
module ccr_sync
	import ccr_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic pin_in,
	output logic      sync_out
);

	typedef struct packed {
		logic first;
		logic second;
	} ccr_sync_s;

	ccr_sync_s st;
	ccr_sync_s next_st;

	always_comb begin
		next_st        = st;
		next_st.first  = pin_in;
		next_st.second = st.first;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '{first: RST_VAL, second: RST_VAL};
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.second;

endmodule

// ---- ccr_byte_reg.sv ----
// file: one writable byte with masked write and reset value.
// assumes: write strobe is one cycle on ref_clk.
`timescale 1ns/1ps
module ccr_byte_reg
	import ccr_pkg::*;
#(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] WR_MASK = 8'hFF
) (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] value
);

	typedef struct packed {
		logic [7:0] val;
	} ccr_byte_s;

	ccr_byte_s st;
	ccr_byte_s next_st;

	always_comb begin
		next_st = st;
		if (wr_en) begin
			next_st.val = wr_data & WR_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st.val <= RST_VAL;
		end else begin
			st <= next_st;
		end
	end

	assign value = st.val;

endmodule

// ---- ccr_regs.sv ----
// How it works
// - clock control byte resets 0x11, reserved read zero
// - bit 4 selects high feedback gain, resets one
// - bit 2 enables analog supply noise suppression
// - bits 1:0 one-hot sampling delay, reset 0x1; a written 0x0 or 0x3 is kept as is
// - 24-bit sysref edge position status reported
// - position register read-only, reads zero until measured
// - channel A range code, resets 0xA000
// - channel B range code, same reset
// - code 0xFFFF is the largest range
// - sysref delay choice four bits, zero for calibration
//
// file: top of the clock and range register bank, reached through a
// four-wire serial port: 1 r/w bit, 15 address bits, then data bytes,
// msb first, sampled on sclk rising edges, sdo changed on falling edges.
// assumes: sclk far slower than ref_clk; pins are asynchronous.
`timescale 1ns/1ps
module ccr_regs
	import ccr_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        spi_csn,
	input  wire logic        spi_sclk,
	input  wire logic        spi_sdi,
	output logic             spi_sdo,
	output logic             spi_sdo_oe,
	input  wire logic [23:0] sysref_edge_position_status_in,
	input  wire logic        sysref_edge_position_status_valid,
	output logic             clk_feedback_high_gain,
	output logic             supply_noise_suppress_enable,
	output logic      [1:0]  sampling_clock_delay_onehot,
	output logic      [15:0] range_code_a,
	output logic      [15:0] range_code_b
);

	typedef struct packed {
		ccr_phase_e  phase;
		logic        sclk_d;
		logic        rd;
		logic [14:0] addr;
		logic [4:0]  bitcnt;
		logic [7:0]  shift;
		logic [7:0]  rdbyte;
		logic [23:0] pos;
		logic        sdo;
		logic        sdo_oe;
		logic        wr_stb;
		logic [14:0] wr_addr;
		logic [7:0]  wr_data;
		logic        gain;
		logic        suppr;
		logic [1:0]  dly;
		logic [15:0] rng_a;
		logic [15:0] rng_b;
	} ccr_regs_s;

	ccr_regs_s st;
	ccr_regs_s next_st;

	logic       csn_s;
	logic       sclk_s;
	logic       sdi_s;
	logic [7:0] clk_cond;
	logic [7:0] sysref_dly;
	logic [7:0] rng_a_lo;
	logic [7:0] rng_a_hi;
	logic [7:0] rng_b_lo;
	logic [7:0] rng_b_hi;
	logic [7:0] rd_mux;

	ccr_sync #(.RST_VAL(1'b1)) u_sync_csn (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.pin_in   (spi_csn),
		.sync_out (csn_s)
	);
	ccr_sync #(.RST_VAL(1'b0)) u_sync_sclk (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.pin_in   (spi_sclk),
		.sync_out (sclk_s)
	);
	ccr_sync #(.RST_VAL(1'b0)) u_sync_sdi (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.pin_in   (spi_sdi),
		.sync_out (sdi_s)
	);

	// writable bytes; reserved clock control bits masked to zero
	ccr_byte_reg #(.RST_VAL(RST_CLK_COND), .WR_MASK(CLK_COND_MASK)) u_cc (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr_en   (st.wr_stb && st.wr_addr == OFS_CLK_COND),
		.wr_data (st.wr_data),
		.value   (clk_cond)
	);
	ccr_byte_reg #(.RST_VAL(RST_RANGE[7:0])) u_ra_lo (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr_en   (st.wr_stb && st.wr_addr == OFS_RANGE_A),
		.wr_data (st.wr_data),
		.value   (rng_a_lo)
	);
	ccr_byte_reg #(.RST_VAL(RST_RANGE[15:8])) u_ra_hi (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr_en   (st.wr_stb && st.wr_addr == OFS_RANGE_A + 15'h0001),
		.wr_data (st.wr_data),
		.value   (rng_a_hi)
	);
	ccr_byte_reg #(.RST_VAL(RST_RANGE[7:0])) u_rb_lo (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr_en   (st.wr_stb && st.wr_addr == OFS_RANGE_B),
		.wr_data (st.wr_data),
		.value   (rng_b_lo)
	);
	ccr_byte_reg #(.RST_VAL(RST_RANGE[15:8])) u_rb_hi (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr_en   (st.wr_stb && st.wr_addr == OFS_RANGE_B + 15'h0001),
		.wr_data (st.wr_data),
		.value   (rng_b_hi)
	);
	// four-bit sysref delay choice; upper bits masked to zero
	ccr_byte_reg #(
		.RST_VAL (RST_SYSREF_DLY),
		.WR_MASK (SYSREF_DLY_MASK)
	) u_sd (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr_en   (st.wr_stb && st.wr_addr == OFS_SYSREF_DLY),
		.wr_data (st.wr_data),
		.value   (sysref_dly)
	);

	// read data; multi-byte fields little endian at rising addresses
	always_comb begin
		case (st.addr)
			OFS_SYSREF_DLY:            rd_mux = sysref_dly;
			OFS_CLK_COND:              rd_mux = clk_cond & CLK_COND_MASK;
			OFS_SYSREF_EDGE_POSITION_STATUS:            rd_mux = st.pos[7:0];
			OFS_SYSREF_EDGE_POSITION_STATUS + 15'h0001: rd_mux = st.pos[15:8];
			OFS_SYSREF_EDGE_POSITION_STATUS + 15'h0002: rd_mux = st.pos[23:16];
			OFS_RANGE_A:               rd_mux = rng_a_lo;
			OFS_RANGE_A + 15'h0001:    rd_mux = rng_a_hi;
			OFS_RANGE_B:               rd_mux = rng_b_lo;
			OFS_RANGE_B + 15'h0001:    rd_mux = rng_b_hi;
			default:                   rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		next_st        = st;
		next_st.sclk_d = sclk_s;
		next_st.wr_stb = 1'b0;
		// position status follows the measurement; never written by software
		if (sysref_edge_position_status_valid) begin
			next_st.pos = sysref_edge_position_status_in;
		end
		// mirrored outputs, all from flip-flops
		next_st.gain  = clk_cond[POS_FB_GAIN];
		next_st.suppr = clk_cond[POS_NOISE_SUPPR];
		next_st.dly   = clk_cond[POS_DELAY_LSB +: 2];
		next_st.rng_a = {rng_a_hi, rng_a_lo};
		next_st.rng_b = {rng_b_hi, rng_b_lo};
		if (csn_s) begin
			next_st.phase  = CCR_IDLE;
			next_st.sdo_oe = 1'b0;
			next_st.bitcnt = 5'h00;
		end else begin
			case (st.phase)
				CCR_IDLE: begin
					next_st.phase  = CCR_HDR;
					next_st.bitcnt = 5'h00;
				end
				CCR_HDR: begin
					if (sclk_s && !st.sclk_d) begin
						if (st.bitcnt == 5'h00) begin
							next_st.rd = sdi_s;
						end else begin
							next_st.addr = {st.addr[13:0], sdi_s};
						end
						if (st.bitcnt == 5'(SPI_CMD_BITS - 9)) begin
							next_st.phase  = CCR_DATA;
							next_st.bitcnt = 5'h00;
						end else begin
							next_st.bitcnt = st.bitcnt + 5'h01;
						end
					end
				end
				CCR_DATA: begin
					if (!sclk_s && st.sclk_d && st.rd) begin
						// falling edge: shift out next read bit
						if (st.bitcnt[2:0] == 3'h0) begin
							next_st.sdo    = rd_mux[7];
							next_st.rdbyte = {rd_mux[6:0], 1'b0};
						end else begin
							next_st.sdo    = st.rdbyte[7];
							next_st.rdbyte = {st.rdbyte[6:0], 1'b0};
						end
						next_st.sdo_oe = 1'b1;
					end
					if (sclk_s && !st.sclk_d) begin
						next_st.shift  = {st.shift[6:0], sdi_s};
						next_st.bitcnt = {2'b00, st.bitcnt[2:0] + 3'h1};
						if (st.bitcnt[2:0] == 3'h7) begin
							// byte done: write if not a read, then stream to next address
							next_st.wr_stb  = !st.rd;
							next_st.wr_addr = st.addr;
							next_st.wr_data = {st.shift[6:0], sdi_s};
							next_st.addr    = st.addr + 15'h0001;
						end
					end
				end
				default: begin
					next_st.phase = CCR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st        <= '0;
			st.phase  <= CCR_IDLE;
			st.pos    <= RST_SYSREF_EDGE_POSITION_STATUS;
			st.gain   <= RST_CLK_COND[POS_FB_GAIN];
			st.suppr  <= RST_CLK_COND[POS_NOISE_SUPPR];
			st.dly    <= DELAY_ONEHOT_RST;
			st.rng_a  <= RST_RANGE;
			st.rng_b  <= RST_RANGE;
		end else begin
			st <= next_st;
		end
	end

	assign spi_sdo                      = st.sdo;
	assign spi_sdo_oe                   = st.sdo_oe;
	assign clk_feedback_high_gain       = st.gain;
	assign supply_noise_suppress_enable = st.suppr;
	assign sampling_clock_delay_onehot  = st.dly;
	assign range_code_a                 = st.rng_a;
	assign range_code_b                 = st.rng_b;

endmodule

// ---- ccr_regs_checker.sv ----
// checker: port-level assertions for the register bank.
// assumes: bound to ccr_regs; one clock, synchronous reset.
`timescale 1ns/1ps
module ccr_regs_checker
	import ccr_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        spi_csn,
	input wire logic        clk_feedback_high_gain,
	input wire logic        supply_noise_suppress_enable,
	input wire logic [1:0]  sampling_clock_delay_onehot,
	input wire logic [15:0] range_code_a,
	input wire logic [15:0] range_code_b
);
	default clocking cb @(posedge ref_clk);
	endclocking
	AST_RST_GAIN: assert property (
		sys_rst |=> clk_feedback_high_gain)
		else $error("gain not high after reset");
	AST_RST_SUPPR: assert property (
		sys_rst |=> !supply_noise_suppress_enable)
		else $error("noise suppression set after reset");
	AST_RST_DELAY: assert property (
		sys_rst |=> sampling_clock_delay_onehot == 2'h1)
		else $error("sampling delay wrong after reset");
	AST_RST_A: assert property (
		sys_rst |=> range_code_a == 16'hA000)
		else $error("range a wrong after reset");
	AST_RST_B: assert property (
		sys_rst |=> range_code_b == 16'hA000)
		else $error("range b wrong after reset");
	AST_HOLD_A: assert property (
		disable iff (sys_rst) spi_csn [*8] |=> $stable(range_code_a))
		else $error("range a moved outside a frame");
	AST_HOLD_B: assert property (
		disable iff (sys_rst) spi_csn [*8] |=> $stable(range_code_b))
		else $error("range b moved outside a frame");
	AST_HOLD_CTL: assert property (disable iff (sys_rst)
		spi_csn [*8] |=> $stable({clk_feedback_high_gain,
		supply_noise_suppress_enable, sampling_clock_delay_onehot}))
		else $error("control bits moved outside a frame");
endmodule

// ---- ccr_regs_tb.sv ----
// testbench: serial port master driving the register bank.
// assumes: sclk phases of 5 ref_clk; bytes little endian.
`timescale 1ns/1ps
module ccr_regs_tb
	import ccr_pkg::*;
;
	logic        ref_clk, sys_rst, spi_csn, spi_sclk, spi_sdi;
	logic        spi_sdo, spi_sdo_oe, sysref_edge_position_status_valid;
	logic        clk_feedback_high_gain, supply_noise_suppress_enable;
	logic [1:0]  sampling_clock_delay_onehot;
	logic [15:0] range_code_a, range_code_b;
	logic [23:0] sysref_edge_position_status_in, rd;
	logic [7:0]  wv [3] = '{8'hFE, 8'h06, 8'h15};
	int          n_errors, n_tests, cyc, n_oe;
	ccr_regs dut (.ref_clk, .sys_rst, .spi_csn, .spi_sclk, .spi_sdi,
		.spi_sdo, .spi_sdo_oe, .sysref_edge_position_status_in, .sysref_edge_position_status_valid,
		.clk_feedback_high_gain, .supply_noise_suppress_enable,
		.sampling_clock_delay_onehot, .range_code_a, .range_code_b);
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic results();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic r, input logic [14:0] a, input int nb,
		input logic [23:0] wd);
		logic [39:0] sh;
		sh = {r, a, wd[7:0], wd[15:8], wd[23:16]};
		rd = 24'h0;
		n_oe = 0;
		spi_csn <= 1'b0;
		tick(5);
		for (int i = 0; i < 16 + 8 * nb; i++) begin
			spi_sdi <= sh[39 - i];
			spi_sclk <= 1'b0;
			tick(5);
			if (i >= 16) begin
				rd[8 * ((i - 16) / 8) + 7 - i % 8] = spi_sdo;
				if (spi_sdo_oe === 1'b1)
					n_oe++;
			end
			spi_sclk <= 1'b1;
			tick(5);
		end
		spi_sclk <= 1'b0;
		tick(5);
		spi_csn <= 1'b1;
		tick(10);
	endtask
	task automatic rc(input string nm, input logic [14:0] a, input int nb,
		input logic [23:0] e);
		xfer(1'b1, a, nb, 24'h0);
		chk(nm, e, rd);
		chk("oe during read", 24'(8 * nb), 24'(n_oe));
		chk("oe after frame", 24'h0, {23'h0, spi_sdo_oe});
	endtask
	function automatic logic [23:0] ctl();
		return {20'h0, clk_feedback_high_gain, supply_noise_suppress_enable,
			sampling_clock_delay_onehot};
	endfunction
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		{sys_rst, spi_csn, spi_sclk, spi_sdi} <= 4'hC;
		{sysref_edge_position_status_in, sysref_edge_position_status_valid} <= 25'h0;
		{n_errors, n_tests, cyc} = '0;
		tick(8);
		sys_rst <= 1'b0;
		tick(4);
		chk("ctl outs", 24'h000009, ctl());
		chk("range a", 24'h00A000, {8'h00, range_code_a});
		chk("range b", 24'h00A000, {8'h00, range_code_b});
		rc("ctl rd", 15'h002B, 1, 24'h000011);
		rc("range a rd", 15'h0030, 2, 24'h00A000);
		rc("status rd", 15'h002C, 3, 24'h000000);
		rc("dly choice rd", 15'h0029, 1, 24'h000000);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b0, 15'h002B, 1, {16'h0, wv[i]});
			chk("oe on write", 24'h0, 24'(n_oe));
			chk("ctl outs", {20'h0, wv[i][4], wv[i][2:0]},
				ctl());
			rc("ctl rd", 15'h002B, 1, {16'h0, wv[i] & 8'h17});
		end
		xfer(1'b0, 15'h0030, 2, {8'h00, RANGE_MIN_REC});
		chk("range a", 24'h002000, {8'h00, range_code_a});
		chk("range b", 24'h00A000, {8'h00, range_code_b});
		xfer(1'b0, 15'h0032, 2, {8'h00, RANGE_MAX});
		rc("range b rd", 15'h0032, 2, 24'h00FFFF);
		chk("range b", 24'h00FFFF, {8'h00, range_code_b});
		xfer(1'b0, 15'h0031, 1, 24'h000055);
		chk("range a", 24'h005500, {8'h00, range_code_a});
		xfer(1'b0, 15'h002F, 3, 24'h3C4599);
		chk("range a", 24'h003C45, {8'h00, range_code_a});
		rc("unmapped rd", 15'h002F, 1, 24'h000000);
		sysref_edge_position_status_in <= 24'hABCDEF;
		sysref_edge_position_status_valid <= 1'b1;
		tick(1);
		sysref_edge_position_status_valid <= 1'b0;
		tick(2);
		rc("status rd", 15'h002C, 3, 24'hABCDEF);
		xfer(1'b0, 15'h0029, 1, {16'h0, rd[7:0]});
		rc("dly choice rd", 15'h0029, 1, 24'h00000F);
		xfer(1'b0, 15'h002C, 3, 24'h123456);
		rc("status rd", 15'h002C, 3, 24'hABCDEF);
		sys_rst <= 1'b1;
		tick(8);
		sys_rst <= 1'b0;
		tick(4);
		chk("range a", 24'h00A000, {8'h00, range_code_a});
		chk("range b", 24'h00A000, {8'h00, range_code_b});
		chk("ctl outs", 24'h000009, ctl());
		rc("dly choice rd", 15'h0029, 1, 24'h000000);
		results();
	end
endmodule
bind ccr_regs ccr_regs_checker chk_i (.ref_clk, .sys_rst, .spi_csn,
	.clk_feedback_high_gain, .supply_noise_suppress_enable,
	.sampling_clock_delay_onehot, .range_code_a, .range_code_b);
